//--- hw/cal_trim_map.svh
/*
  Register offsets, field positions, reset values and timing figures
  for the calibration and trim control block.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef CAL_TRIM_MAP_SVH
`define CAL_TRIM_MAP_SVH

// ------------------------------------------------------------
// register byte offsets (APB, one word each)
// ------------------------------------------------------------
`define CT_CAL_CFG_ADDR 12'h000
`define CT_LP_CFG_ADDR 12'h004
`define CT_TRIG_ADDR 12'h008
`define CT_STATUS_ADDR 12'h00C
`define CT_OFS_TRIM_ADDR 12'h010
`define CT_GAIN_TRIM_ADDR 12'h014
`define CT_TIME_TRIM_ADDR 12'h018
`define CT_FS_RANGE_ADDR 12'h01C

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CT_CFG_CAL_EN 0
`define CT_CFG_BG_EN 1
`define CT_CFG_FG_OS 2
`define CT_CFG_BG_OS 3
`define CT_CFG_LOWPOWER_BG_ENABLE 4
`define CT_CFG_LOWPOWER_TRIGGER_SELECT 5
`define CT_CFG_PIN_SEL 6
`define CT_CFG_SINGLE 7
`define CT_CFG_RESET 32'h0000_0001

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define CT_ST_FOREGROUND_DONE_FLAG 0
`define CT_ST_MIDCODE 1
`define CT_ST_SPARE_PWR 2
`define CT_ST_STATE_LSB 4
`define CT_ST_CORE_LSB 8

// ------------------------------------------------------------
// trim reset values and timing
// ------------------------------------------------------------
`define CT_FS_RANGE_RESET 16'hA000
`define CT_TRIM_RESET 16'h0000
`define CT_CAL_STEP_CYCLES 16'h0040
`define CT_DELAY_UNIT 16'h0100
`define CT_MIDCODE 12'h000
`define CT_CORES 2'h3

`endif

//--- hw/cal_trim_pkg.sv
/*
  Types for the calibration and trim control block.
  Assumes the map header is on the include path.
*/
package cal_trim_pkg;
  `include "cal_trim_map.svh"

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_fg_cal = 3'b001,
    st_fg_ofs = 3'b010,
    st_sleep = 3'b011,
    st_wake = 3'b100,
    st_bg_cal = 3'b101,
    st_swap = 3'b110,
    st_bg_ofs = 3'b111
  } cal_state_t;
endpackage : cal_trim_pkg

//--- hw/cal_trim_control.sv
/*
  Calibration sequencer and trim register file: foreground and
  background calibration, low-power spare sleep/wake, core swapping,
  buffer offset correction and trim selection by channel mode.
  Assumes an APB master on clock, a synchronous active-high reset and
  an asynchronous trigger pin from outside.
*/
`timescale 1ns/100ps
`include "cal_trim_map.svh"

// Overview of operation
// - low-power mode powers down idle spare core
// - sleep delay sets spare sleep time
// - wake delay sets stabilise time before calibration
// - trigger select: automatic or user paced swap
// - foreground offset calibrated once per foreground run
// - background offset corrected each background cycle
// - offset calibration owns offset trims; host stays off
// - zero-phase offset both/core B; quad core A
// - bank timing zero-phase both banks; quad bank 1
// - foreground calibration forces midcode output
// - trigger source pin or software by select
module cal_trim_control
  import cal_trim_pkg::*;
#(
  parameter int CAL_CYCLES = `CT_CAL_STEP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger pin
  input wire logic cal_trigger_pin,
  // converter side
  input wire logic [11:0] offset_estimate,
  output logic [11:0] conv_data_override,
  output logic output_midcode,
  output logic spare_core_powered,
  output logic [1:0] offline_core,
  output logic [15:0] core_a_offset_trim,
  output logic [15:0] core_b_offset_trim,
  output logic [15:0] bank0_timing_trim,
  output logic [15:0] bank1_timing_trim
);
  if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_bad_cal_cycles
    $error("CAL_CYCLES out of range");
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] cal_cfg;
  logic [15:0] spare_sleep_delay;
  logic [15:0] spare_wake_delay;
  logic software_cal_trigger;
  logic foreground_done_flag;
  logic [15:0] core_a_zero_offset_trim;
  logic [15:0] core_a_quad_offset_trim;
  logic [15:0] core_b_zero_offset_trim;
  logic [15:0] bank_gain_trim_dual;
  logic [15:0] bank_gain_trim_single;
  logic [15:0] bank_timing_trim_zero;
  logic [15:0] bank_timing_trim_quad;
  logic [15:0] fullscale_range_setting;
  cal_state_t state;
  cal_state_t next_state;
  logic [31:0] count;
  logic [1:0] pin_sync;
  logic pin_prev;
  logic sw_prev;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire wr = psel && penable && pwrite;
  wire rd_addr_ok = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  wire cal_en = cal_cfg[`CT_CFG_CAL_EN];
  wire background_cal_enable = cal_cfg[`CT_CFG_BG_EN];
  wire foreground_offset_enable = cal_cfg[`CT_CFG_FG_OS];
  wire background_offset_enable = cal_cfg[`CT_CFG_BG_OS];
  wire single_mode = cal_cfg[`CT_CFG_SINGLE];
  wire cal_trigger_pin_select = cal_cfg[`CT_CFG_PIN_SEL];
  wire lowpower_trigger_select = cal_cfg[`CT_CFG_LOWPOWER_TRIGGER_SELECT];
  wire lowpower_bg_enable = cal_cfg[`CT_CFG_LOWPOWER_BG_ENABLE] && background_cal_enable;
  wire pin_rise = pin_sync[1] && !pin_prev;
  wire sw_rise = software_cal_trigger && !sw_prev;
  wire user_trigger = cal_trigger_pin_select ? pin_rise : sw_rise;
  wire ofs_locked = foreground_offset_enable || background_offset_enable;
  wire trim_allowed = !background_cal_enable;
  wire done_count = (count >= 32'(CAL_CYCLES));
  wire [31:0] sleep_cycles = 32'(spare_sleep_delay) * 32'(`CT_DELAY_UNIT);
  wire [31:0] wake_cycles = 32'(spare_wake_delay) * 32'(`CT_DELAY_UNIT);
  wire [15:0] ofs_corr = {{4{offset_estimate[11]}}, offset_estimate};
  wire in_fg = (state == st_fg_cal) || (state == st_fg_ofs);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (background_cal_enable && cal_en)
          next_state = lowpower_bg_enable ? st_sleep : st_bg_cal;
        else if (cal_en && user_trigger)
          next_state = st_fg_cal;
      end
      st_fg_cal: begin
        // one offset pass per foreground run
        if (done_count)
          next_state = foreground_offset_enable ? st_fg_ofs : st_idle;
      end
      st_fg_ofs: if (done_count) next_state = st_idle;
      st_sleep: begin
        if (!background_cal_enable) next_state = st_idle;
        else if (lowpower_trigger_select ? user_trigger : (count >= sleep_cycles)) next_state = st_wake;
      end
      st_wake: if (count >= wake_cycles) next_state = st_bg_cal;
      st_bg_cal: begin
        if (done_count)
          next_state = background_offset_enable ? st_bg_ofs : st_swap;
      end
      st_bg_ofs: if (done_count) next_state = st_swap;
      st_swap: begin
        if (!background_cal_enable) next_state = st_idle;
        else if (lowpower_bg_enable) next_state = st_sleep;
        else if (!lowpower_trigger_select || user_trigger || !cal_cfg[`CT_CFG_LOWPOWER_BG_ENABLE]) next_state = st_bg_cal;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= st_idle;
      count <= 32'h0000_0000;
      pin_sync <= 2'h0;
      pin_prev <= 1'b0;
      sw_prev <= 1'b0;
      offline_core <= 2'h2;
    end else begin
      state <= next_state;
      count <= (next_state != state) ? 32'h0000_0000 : count + 32'h0000_0001;
      pin_sync <= {pin_sync[0], cal_trigger_pin};
      pin_prev <= pin_sync[1];
      sw_prev <= software_cal_trigger;
      if (state == st_swap && next_state != st_swap)
        offline_core <= (offline_core == 2'h2) ? 2'h0 : offline_core + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cal_cfg <= 8'(`CT_CFG_RESET);
      spare_sleep_delay <= `CT_TRIM_RESET;
      spare_wake_delay <= `CT_TRIM_RESET;
      software_cal_trigger <= 1'b0;
      foreground_done_flag <= 1'b0;
      core_a_zero_offset_trim <= `CT_TRIM_RESET;
      core_a_quad_offset_trim <= `CT_TRIM_RESET;
      core_b_zero_offset_trim <= `CT_TRIM_RESET;
      bank_gain_trim_dual <= `CT_TRIM_RESET;
      bank_gain_trim_single <= `CT_TRIM_RESET;
      bank_timing_trim_zero <= `CT_TRIM_RESET;
      bank_timing_trim_quad <= `CT_TRIM_RESET;
      fullscale_range_setting <= `CT_FS_RANGE_RESET;
    end else begin
      if (wr && paddr == `CT_CAL_CFG_ADDR) cal_cfg <= pwdata[7:0];
      if (wr && paddr == `CT_LP_CFG_ADDR) begin
        spare_sleep_delay <= pwdata[15:0];
        spare_wake_delay <= pwdata[31:16];
      end
      if (wr && paddr == `CT_TRIG_ADDR) software_cal_trigger <= pwdata[0];
      // done set wins over clear on start
      if (state == st_fg_ofs && done_count || state == st_fg_cal && done_count && !foreground_offset_enable)
        foreground_done_flag <= 1'b1;
      else if (next_state == st_fg_cal && state == st_idle)
        foreground_done_flag <= 1'b0;
      if ((state == st_fg_ofs || state == st_bg_ofs) && done_count) begin
        core_a_zero_offset_trim <= ofs_corr;
        core_a_quad_offset_trim <= ofs_corr;
        core_b_zero_offset_trim <= ofs_corr;
      end else if (wr && paddr == `CT_OFS_TRIM_ADDR && !ofs_locked && trim_allowed) begin
        core_a_zero_offset_trim <= pwdata[15:0];
        core_a_quad_offset_trim <= pwdata[15:0];
        core_b_zero_offset_trim <= pwdata[31:16];
      end
      if (wr && paddr == `CT_GAIN_TRIM_ADDR && trim_allowed) begin
        bank_gain_trim_dual <= pwdata[15:0];
        bank_gain_trim_single <= pwdata[31:16];
      end
      if (wr && paddr == `CT_TIME_TRIM_ADDR && trim_allowed) begin
        bank_timing_trim_zero <= pwdata[15:0];
        bank_timing_trim_quad <= pwdata[31:16];
      end
      if (wr && paddr == `CT_FS_RANGE_ADDR) fullscale_range_setting <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // midcode during foreground
  assign output_midcode = in_fg;
  assign conv_data_override = `CT_MIDCODE;
  assign spare_core_powered = !(lowpower_bg_enable && (state == st_sleep || state == st_idle));
  assign core_a_offset_trim = single_mode ? core_a_quad_offset_trim : core_a_zero_offset_trim;
  assign core_b_offset_trim = core_b_zero_offset_trim;
  assign bank0_timing_trim = bank_timing_trim_zero;
  assign bank1_timing_trim = single_mode ? bank_timing_trim_quad : bank_timing_trim_zero;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_addr_ok;
  always_ff @(posedge clock) begin
    if (sys_rst) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CT_CAL_CFG_ADDR: prdata <= {24'h000000, cal_cfg};
        `CT_LP_CFG_ADDR: prdata <= {spare_wake_delay, spare_sleep_delay};
        `CT_TRIG_ADDR: prdata <= {31'h00000000, software_cal_trigger};
        `CT_STATUS_ADDR: prdata <= {22'h000000, offline_core, 1'b0, state, 1'b0,
                                    spare_core_powered, output_midcode, foreground_done_flag};
        `CT_OFS_TRIM_ADDR: prdata <= {core_b_zero_offset_trim, core_a_zero_offset_trim};
        `CT_GAIN_TRIM_ADDR: prdata <= {bank_gain_trim_single, bank_gain_trim_dual};
        `CT_TIME_TRIM_ADDR: prdata <= {bank_timing_trim_quad, bank_timing_trim_zero};
        `CT_FS_RANGE_ADDR: prdata <= {16'h0000, fullscale_range_setting};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_fg_midcode: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_fg_cal) |-> output_midcode) else $error("midcode missing in foreground");
  a_spare_sleep: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_sleep && lowpower_bg_enable) |-> !spare_core_powered) else $error("spare awake while sleeping");
  a_lp_gated: assert property (@(posedge clock) disable iff (sys_rst)
    (!background_cal_enable && state == st_idle) |-> spare_core_powered ##1 (state != st_sleep && state != st_wake))
    else $error("low power active without background");
  a_wake_order: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_wake && next_state == st_bg_cal) |-> count >= wake_cycles) else $error("wake too short");
  a_sleep_auto: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_sleep && next_state == st_wake && !lowpower_trigger_select) |-> count >= sleep_cycles)
    else $error("sleep ended early");
  a_fg_offset: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_fg_cal && done_count && foreground_offset_enable) |=> state == st_fg_ofs)
    else $error("foreground offset skipped");
  a_bg_offset: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_bg_cal && done_count && background_offset_enable) |=> state == st_bg_ofs)
    else $error("background offset skipped");
  a_trim_mode: assert property (@(posedge clock) disable iff (sys_rst)
    single_mode |-> core_a_offset_trim == core_a_quad_offset_trim) else $error("wrong offset phase");
  a_time_phase: assert property (@(posedge clock) disable iff (sys_rst)
    !single_mode |-> bank1_timing_trim == bank_timing_trim_zero) else $error("wrong timing phase");
  a_trig_src: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_idle && cal_en && !background_cal_enable && user_trigger) |=> state == st_fg_cal)
    else $error("trigger ignored");
  a_user_pace: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_sleep && lowpower_trigger_select && !user_trigger && background_cal_enable) |=> state == st_sleep)
    else $error("swap without user trigger");
  a_ofs_lock: assert property (@(posedge clock) disable iff (sys_rst)
    (ofs_locked && wr && paddr == `CT_OFS_TRIM_ADDR && !(state == st_fg_ofs || state == st_bg_ofs))
    |=> $stable(core_b_zero_offset_trim)) else $error("host wrote locked offset trim");
endmodule : cal_trim_control

//--- bench/tb_top.sv
/*
  Self-checking bench for the calibration and trim control block.
  Assumes the design package and map header are compiled first.
*/
`timescale 1ns/100ps
`include "cal_trim_map.svh"

module tb_top
  import cal_trim_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cal_trigger_pin = 1'b0;
  logic [11:0] offset_estimate = 12'h000;
  logic [11:0] conv_data_override;
  logic output_midcode;
  logic spare_core_powered;
  logic [1:0] offline_core;
  logic [15:0] core_a_offset_trim;
  logic [15:0] core_b_offset_trim;
  logic [15:0] bank0_timing_trim;
  logic [15:0] bank1_timing_trim;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;

  cal_trim_control #(.CAL_CYCLES(4)) cal_trim_control_inst (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_trigger_pin(cal_trigger_pin), .offset_estimate(offset_estimate),
    .conv_data_override(conv_data_override), .output_midcode(output_midcode),
    .spare_core_powered(spare_core_powered), .offline_core(offline_core),
    .core_a_offset_trim(core_a_offset_trim), .core_b_offset_trim(core_b_offset_trim),
    .bank0_timing_trim(bank0_timing_trim), .bank1_timing_trim(bank1_timing_trim)
  );

  always #12.5 clock = ~clock;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic sw_trig();
    apb(1'b1, `CT_TRIG_ADDR, 32'h0000_0001);
    apb(1'b1, `CT_TRIG_ADDR, 32'h0000_0000);
  endtask : sw_trig

  function automatic logic [15:0] obs(input int sel);
    case (sel)
      0: obs = {15'h0000, output_midcode};
      1: obs = {15'h0000, spare_core_powered};
      2: obs = {14'h0000, offline_core};
      default: obs = core_a_offset_trim;
    endcase
  endfunction : obs

  // stay=1: must hold exp for n cycles; stay=0: must reach exp within n
  task automatic watch(input int sel, input logic [15:0] exp, input int n, input bit stay);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clock);
      #1;
      if ((obs(sel) === exp) != stay) break;
    end
    check({16'h0000, obs(sel)}, {16'h0000, exp});
  endtask : watch

  task automatic do_reset();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
  endtask : do_reset

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_and_map();
    apb(1'b0, `CT_CAL_CFG_ADDR, 32'h0); check(rd, 32'h0000_0001);
    apb(1'b0, `CT_FS_RANGE_ADDR, 32'h0); check(rd, 32'h0000_A000);
    apb(1'b0, `CT_STATUS_ADDR, 32'h0); check(rd, 32'h0000_0204);
    apb(1'b0, 12'h020, 32'h0); check({rd[31:1], er}, 32'h0000_0001);
  endtask : t_reset_and_map

  task automatic t_trim_select();
    apb(1'b1, `CT_OFS_TRIM_ADDR, 32'h2222_1111);
    apb(1'b1, `CT_TIME_TRIM_ADDR, 32'h4444_3333);
    check({core_b_offset_trim, core_a_offset_trim}, 32'h2222_1111);
    check({bank1_timing_trim, bank0_timing_trim}, 32'h3333_3333);
    apb(1'b1, `CT_CAL_CFG_ADDR, 32'h0000_0081);
    check({bank1_timing_trim, bank0_timing_trim}, 32'h4444_3333);
    apb(1'b1, `CT_OFS_TRIM_ADDR, 32'h2222_1111);
    check({core_b_offset_trim, core_a_offset_trim}, 32'h2222_1111);
    apb(1'b1, `CT_CAL_CFG_ADDR, 32'h0000_0001);
    apb(1'b1, `CT_GAIN_TRIM_ADDR, 32'h0011_0011);
    apb(1'b0, `CT_GAIN_TRIM_ADDR, 32'h0);
    check(rd, 32'h0011_0011);
    apb(1'b1, `CT_FS_RANGE_ADDR, 32'h0000_B000);
    apb(1'b0, `CT_FS_RANGE_ADDR, 32'h0);
    check(rd, 32'h0000_B000);
  endtask : t_trim_select

  task automatic t_fg_offset();
    int i;
    @(posedge clock);
    offset_estimate <= 12'hF80;
    apb(1'b1, `CT_CAL_CFG_ADDR, 32'h0000_0005);
    apb(1'b1, `CT_OFS_TRIM_ADDR, 32'h5555_5555);
    check({core_b_offset_trim, core_a_offset_trim}, 32'h2222_1111);
    sw_trig();
    watch(0, 16'h0001, 20, 1'b0);
    check({20'h00000, conv_data_override}, 32'h0000_0000);
    for (i = 0; i < 50; i++) begin
      apb(1'b0, `CT_STATUS_ADDR, 32'h0);
      if (rd[0] === 1'b1) break;
    end
    check({31'h0, rd[0]}, 32'h1);
    check({core_b_offset_trim, core_a_offset_trim}, 32'hFF80_FF80);
    check({31'h0, output_midcode}, 32'h0);
    apb(1'b0, `CT_OFS_TRIM_ADDR, 32'h0);
    check(rd, 32'hFF80_FF80);
    @(posedge clock);
    offset_estimate <= 12'h055;
    watch(3, 16'hFF80, 60, 1'b1);
  endtask : t_fg_offset

  task automatic t_pin_trigger();
    apb(1'b1, `CT_CAL_CFG_ADDR, 32'h0000_0041);
    sw_trig();
    watch(0, 16'h0000, 20, 1'b1);
    @(posedge clock);
    cal_trigger_pin <= 1'b1;
    repeat (3) @(posedge clock);
    cal_trigger_pin <= 1'b0;
    watch(0, 16'h0001, 10, 1'b0);
    watch(0, 16'h0000, 40, 1'b0);
  endtask : t_pin_trigger

  task automatic t_lowpower();
    apb(1'b1, `CT_LP_CFG_ADDR, 32'h0001_0001);
    apb(1'b1, `CT_CAL_CFG_ADDR, 32'h0000_0011);
    watch(1, 16'h0001, 300, 1'b1);
    apb(1'b1, `CT_CAL_CFG_ADDR, 32'h0000_0013);
    watch(1, 16'h0000, 600, 1'b0);
    watch(1, 16'h0000, 200, 1'b1);
    watch(1, 16'h0001, 400, 1'b0);
    watch(2, 16'h0002, 200, 1'b1);
    watch(2, 16'h0000, 400, 1'b0);
  endtask : t_lowpower

  task automatic t_user_paced();
    do_reset();
    apb(1'b1, `CT_LP_CFG_ADDR, 32'h0001_0001);
    apb(1'b1, `CT_CAL_CFG_ADDR, 32'h0000_0033);
    watch(2, 16'h0002, 1500, 1'b1);
    sw_trig();
    watch(2, 16'h0000, 1500, 1'b0);
  endtask : t_user_paced

  task automatic t_bg_offset();
    do_reset();
    offset_estimate <= 12'h010;
    apb(1'b1, `CT_CAL_CFG_ADDR, 32'h0000_000B);
    apb(1'b1, `CT_GAIN_TRIM_ADDR, 32'h1234_5678);
    apb(1'b0, `CT_GAIN_TRIM_ADDR, 32'h0); check(rd, 32'h0000_0000);
    watch(3, 16'h0010, 2000, 1'b0);
    @(posedge clock);
    offset_estimate <= 12'h7F0;
    watch(3, 16'h07F0, 2000, 1'b0);
  endtask : t_bg_offset

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset_and_map();
    t_trim_select();
    t_fg_offset();
    t_pin_trigger();
    t_lowpower();
    t_user_paced();
    t_bg_offset();
    summarize();
  end
endmodule : tb_top
